// ### hdl/odurc_pkg.sv
package odurc_pkg;

    // Frame layout of one 24-bit command word
    localparam int unsigned FRAME_W        = 24;
    localparam int unsigned CMD_MSB        = 23;
    localparam int unsigned CMD_LSB        = 20;
    localparam int unsigned ADDR_MSB       = 19;
    localparam int unsigned ADDR_LSB       = 16;
    localparam int unsigned PD_ZERO_BIT    = 19;
    localparam int unsigned DATA_MSB       = 15;
    localparam int unsigned MASK_MSB       = 7;

    // Channel geometry
    localparam int unsigned NUM_CHAN       = 8;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned PD_W           = 2;

    // Command codes
    localparam logic [3:0]  CMD_WRITE_INPUT  = 4'h1;
    localparam logic [3:0]  CMD_UPDATE_DAC   = 4'h2;
    localparam logic [3:0]  CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0]  CMD_POWER_DOWN   = 4'h4;
    localparam logic [3:0]  CMD_LOAD_MASK    = 4'h5;
    localparam logic [3:0]  CMD_SOFT_RESET   = 4'h6;

    // Software reset key
    localparam logic [3:0]  SOFT_RESET_ADDR  = 4'h0;
    localparam logic [15:0] SOFT_RESET_KEY   = 16'h1234;

    // Reset values and output codes
    localparam logic [7:0]  MASK_RESET       = 8'h00;
    localparam logic [15:0] PWRDN_RESET      = 16'h0000;
    localparam logic [15:0] ZERO_SCALE_CODE  = 16'h0000;
    localparam logic [15:0] MID_SCALE_CODE   = 16'h8000;

    // Power-down mode encodings per channel
    localparam logic [1:0]  PD_NORMAL        = 2'h0;
    localparam logic [1:0]  PD_PULLDOWN      = 2'h1;

    typedef enum logic {
        ST_INIT,
        ST_RUN
    } odurc_state_t;

endpackage : odurc_pkg

// ### hdl/odurc_update_ctrl.sv
`timescale 1ns/100ps

module odurc_update_ctrl (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         frameValid,
    input  wire logic [23:0]  frameData,
    input  wire logic         load_strobe_n,
    input  wire logic         clear_n,
    input  wire logic         clear_level_select,
    output logic      [127:0] dacCode,
    output logic      [15:0]  pwrdnMode,
    output logic      [7:0]   chanPulldown,
    output logic      [7:0]   chanTristate,
    output logic              initDone
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and frame decode

    logic                     strobeSync1_q;
    logic                     strobeSync2_q;
    logic                     strobePrev_q;
    logic                     clearSync1_q;
    logic                     clearSync2_q;
    logic                     levelSync1_q;
    logic                     levelSync2_q;
    odurc_pkg::odurc_state_t  state_q;
    logic [7:0]               loadMask_q;
    logic [15:0]              pwrdnMode_q;
    logic [15:0]              inputReg_q [odurc_pkg::NUM_CHAN];
    logic [15:0]              dacReg_q   [odurc_pkg::NUM_CHAN];

    logic                     isRun;
    logic                     strobeFall;
    logic                     frameRun;
    logic [3:0]               cmdField;
    logic [3:0]               addrField;
    logic [15:0]              dataField;
    logic [15:0]              clearCode;
    logic                     softResetHit;

    // Two flops per pin; the strobe has a third (strobePrev_q), and logic reads it and the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strobeSync1_q <= 1'b1;
            strobeSync2_q <= 1'b1;
            strobePrev_q  <= 1'b1;
            clearSync1_q  <= 1'b0;
            clearSync2_q  <= 1'b0;
            levelSync1_q  <= 1'b0;
            levelSync2_q  <= 1'b0;
        end else begin
            strobeSync1_q <= load_strobe_n;
            strobeSync2_q <= strobeSync1_q;
            strobePrev_q  <= strobeSync2_q; // Tracks in init too, so no false edge at exit
            clearSync1_q  <= clear_n;
            clearSync2_q  <= clearSync1_q;
            levelSync1_q  <= clear_level_select;
            levelSync2_q  <= levelSync1_q;
        end
    end

    // Field split of the finished frame
    assign cmdField   = frameData[odurc_pkg::CMD_MSB:odurc_pkg::CMD_LSB];
    assign addrField  = frameData[odurc_pkg::ADDR_MSB:odurc_pkg::ADDR_LSB];
    assign dataField  = frameData[odurc_pkg::DATA_MSB:0];
    assign isRun      = (state_q == odurc_pkg::ST_RUN);
    assign frameRun   = frameValid && isRun;
    assign strobeFall = isRun && strobePrev_q && !strobeSync2_q;
    assign clearCode  = levelSync2_q ? odurc_pkg::MID_SCALE_CODE
                                     : odurc_pkg::ZERO_SCALE_CODE;
    assign softResetHit = frameRun && (cmdField == odurc_pkg::CMD_SOFT_RESET)
                          && (addrField == odurc_pkg::SOFT_RESET_ADDR)
                          && (dataField == odurc_pkg::SOFT_RESET_KEY);

    ////////////////////////////////////////////////////////////////////////////
    // Initialisation state

    // Init is left only once clear is seen high; a keyed reset re-enters it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= odurc_pkg::ST_INIT;
        end else begin
            unique case (state_q)
                odurc_pkg::ST_INIT: begin
                    if (clearSync2_q) begin
                        state_q <= odurc_pkg::ST_RUN;
                    end
                end
                odurc_pkg::ST_RUN: begin
                    if (softResetHit) begin
                        state_q <= odurc_pkg::ST_INIT;
                    end
                end
            endcase
        end
    end

    assign initDone = isRun;

    ////////////////////////////////////////////////////////////////////////////
    // Load mask and power-down registers

    // Mask acts from the cycle after its frame, and gates strobe edges only, not commands
    always_ff @(posedge clk) begin
        if (sys_rst || softResetHit) begin
            loadMask_q <= odurc_pkg::MASK_RESET;
        end else if (frameRun && (cmdField == odurc_pkg::CMD_LOAD_MASK)) begin
            loadMask_q <= frameData[odurc_pkg::MASK_MSB:0];
        end
    end

    // Bit 19 must be zero; bits 18:16 are don't care
    always_ff @(posedge clk) begin
        if (sys_rst || softResetHit) begin
            pwrdnMode_q <= odurc_pkg::PWRDN_RESET;
        end else if (frameRun && (cmdField == odurc_pkg::CMD_POWER_DOWN)
                     && !frameData[odurc_pkg::PD_ZERO_BIT]) begin
            pwrdnMode_q <= dataField;
        end
    end

    assign pwrdnMode = pwrdnMode_q;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel input and DAC registers

    genvar gi;
    generate
        for (gi = 0; gi < odurc_pkg::NUM_CHAN; gi++) begin : gChan
            logic hit;
            logic wrInput;
            logic wrDacData;
            logic cpDac;

            // Addresses above 7 select nothing
            assign hit       = frameRun && (addrField == 4'(gi));
            assign wrInput   = hit && ((cmdField == odurc_pkg::CMD_WRITE_INPUT)
                                       || (cmdField == odurc_pkg::CMD_WRITE_UPDATE));
            // Strobe low at frame end overrides the mask
            assign wrDacData = hit && ((cmdField == odurc_pkg::CMD_WRITE_UPDATE)
                                       || ((cmdField == odurc_pkg::CMD_WRITE_INPUT)
                                           && !strobeSync2_q));
            assign cpDac     = hit && (cmdField == odurc_pkg::CMD_UPDATE_DAC);

            // Clear and init both park the pair at the clear code, so a later
            // strobe edge cannot bring back a stale input value
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    inputReg_q[gi] <= odurc_pkg::ZERO_SCALE_CODE;
                    dacReg_q[gi]   <= odurc_pkg::ZERO_SCALE_CODE;
                end else if (!isRun || !clearSync2_q) begin
                    inputReg_q[gi] <= clearCode;
                    dacReg_q[gi]   <= clearCode;
                end else begin
                    if (wrInput) begin
                        inputReg_q[gi] <= dataField;
                    end
                    if (wrDacData) begin
                        dacReg_q[gi] <= dataField;
                    end else if (cpDac) begin
                        dacReg_q[gi] <= inputReg_q[gi];
                    end else if (strobeFall && !loadMask_q[gi]) begin
                        dacReg_q[gi] <= inputReg_q[gi];
                    end
                end
            end

            assign dacCode[gi*16 +: 16] = dacReg_q[gi];
            // Mode 10 is undefined; any set high bit is taken as tristate
            assign chanPulldown[gi] = (pwrdnMode_q[gi*2 +: 2] == odurc_pkg::PD_PULLDOWN);
            assign chanTristate[gi] = pwrdnMode_q[gi*2 + 1];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cbChk @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic        wrCh0;
    logic [15:0] dac0;
    assign wrCh0 = frameRun && (addrField == 4'h0) && clearSync2_q;
    assign dac0  = dacCode[15:0];

    chk_mask_init_zero: assert property (
        !isRun |-> (loadMask_q == odurc_pkg::MASK_RESET))
        else $error("load mask not cleared during init");

    chk_mask_load_value: assert property (
        (frameRun && cmdField == odurc_pkg::CMD_LOAD_MASK && !softResetHit)
        |=> (loadMask_q == $past(frameData[7:0])))
        else $error("load mask not taken from data bits");

    chk_pd_frame_load: assert property (
        (frameRun && cmdField == odurc_pkg::CMD_POWER_DOWN && !frameData[19])
        |=> (pwrdnMode_q == $past(frameData[15:0])))
        else $error("power-down modes not loaded");

    chk_clear_forces_code: assert property (
        (isRun && !clearSync2_q) |=> (dac0 == $past(clearCode)))
        else $error("clear did not force clear code");

    chk_clear_holds_after: assert property (
        (isRun && !clearSync2_q)[*2] ##1 (!frameRun && !strobeFall)
        |=> $stable(dac0))
        else $error("output moved after clear with no update");

    chk_soft_reset_key: assert property (
        (frameRun && cmdField == odurc_pkg::CMD_SOFT_RESET
         && addrField == odurc_pkg::SOFT_RESET_ADDR
         && dataField == odurc_pkg::SOFT_RESET_KEY)
        |=> !initDone ##1 (loadMask_q == odurc_pkg::MASK_RESET))
        else $error("keyed software reset not taken");

    chk_soft_reset_wrong: assert property (
        (frameRun && cmdField == odurc_pkg::CMD_SOFT_RESET && dataField != odurc_pkg::SOFT_RESET_KEY)
        |=> initDone)
        else $error("software reset taken with wrong key");

    chk_init_waits_clear: assert property (
        (!isRun && !clearSync2_q) |=> !initDone)
        else $error("init completed while clear held low");

    chk_write_update_ch0: assert property (
        (wrCh0 && cmdField == odurc_pkg::CMD_WRITE_UPDATE)
        |=> (dac0 == $past(dataField)))
        else $error("write-and-update did not reach DAC");

    chk_deferred_write: assert property (
        (wrCh0 && cmdField == odurc_pkg::CMD_WRITE_INPUT && strobeSync2_q && !strobeFall)
        |=> $stable(dac0))
        else $error("deferred write changed DAC");

    chk_masked_edge_ignored: assert property (
        (strobeFall && loadMask_q[0] && !frameRun && clearSync2_q) |=> $stable(dac0))
        else $error("masked channel followed strobe edge");

    // A frame with bit 19 set must not disturb the modes already in place
    chk_pd_bit19_ignored: assert property (
        (frameRun && cmdField == odurc_pkg::CMD_POWER_DOWN && frameData[odurc_pkg::PD_ZERO_BIT])
        |=> $stable(pwrdnMode_q))
        else $error("power-down frame with bit 19 set was taken");

    chk_strobe_copy: assert property (
        (strobeFall && !loadMask_q[0] && clearSync2_q && !frameRun)
        |=> (dac0 == $past(inputReg_q[0])))
        else $error("strobe edge did not copy input register");

    // The three addressed checks below cover every channel, not only channel 0
    chk_copy_command: assert property (
        (frameRun && clearSync2_q && !addrField[3] && cmdField == odurc_pkg::CMD_UPDATE_DAC)
        |=> (dacReg_q[$past(addrField[2:0])] == $past(inputReg_q[addrField[2:0]])))
        else $error("update command did not copy input register");

    chk_level_write: assert property (
        (frameRun && clearSync2_q && !addrField[3] && cmdField == odurc_pkg::CMD_WRITE_INPUT
         && !strobeSync2_q)
        |=> (dacReg_q[$past(addrField[2:0])] == $past(dataField)))
        else $error("write with strobe low did not reach DAC");

    chk_input_write: assert property (
        (frameRun && clearSync2_q && !addrField[3] && cmdField == odurc_pkg::CMD_WRITE_INPUT)
        |=> (inputReg_q[$past(addrField[2:0])] == $past(dataField)))
        else $error("write command did not load input register");

    chk_powerup_level: assert property (
        !isRun |=> (dac0 == $past(clearCode)))
        else $error("init did not park output at clear code");

    chk_pd_pulldown: assert property (
        (pwrdnMode_q[1:0] == odurc_pkg::PD_PULLDOWN) |-> (chanPulldown[0] && !chanTristate[0]))
        else $error("pull-down mode decoded wrongly");

    chk_pd_tristate: assert property (
        (pwrdnMode_q[15] && pwrdnMode_q[14]) |-> (chanTristate[7] && !chanPulldown[7]))
        else $error("tristate mode decoded wrongly");

    // Input side is parked too, so a strobe after release cannot revive old data
    chk_clear_input: assert property (
        (isRun && !clearSync2_q) |=> (inputReg_q[0] == $past(clearCode)))
        else $error("clear left input register writable");

    cov_strobe_update: cover property (strobeFall && !loadMask_q[0] && clearSync2_q);
    cov_soft_reset:    cover property (softResetHit);
    cov_clear_release: cover property (isRun && !clearSync2_q ##1 clearSync2_q);
    cov_immediate:     cover property (wrCh0 && cmdField == odurc_pkg::CMD_WRITE_INPUT && !strobeSync2_q);

endmodule : odurc_update_ctrl

// ### bench/odurc_frame_master.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Far-side master: hands over finished 24-bit command frames, one per call
module odurc_frame_master (
    input  wire logic        clk,
    output logic             frameValid,
    output logic [23:0]      frameData
);

    // Idle at time zero; no frame pending
    initial begin
        frameValid = 1'b0;
        frameData  = 24'h000000;
    end

    // One whole frame per call; between frames the word is inverted so stale data never passes for a frame
    task automatic send(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] data);
        @(negedge clk);
        frameData  = {cmd, addr, data};
        frameValid = 1'b1;
        @(negedge clk);
        frameValid = 1'b0;
        frameData  = ~frameData;
    endtask : send

endmodule : odurc_frame_master

// ### bench/tb_odurc_update_ctrl.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the update and reset control
module tb_odurc_update_ctrl;

    logic         clk;
    logic         sys_rst;
    logic         load_strobe_n;
    logic         clear_n;
    logic         clear_level_select;
    logic         frameValid;
    logic [23:0]  frameData;
    logic [127:0] dacCode;
    logic [15:0]  pwrdnMode;
    logic [7:0]   chanPulldown;
    logic [7:0]   chanTristate;
    logic         initDone;
    int           errTotal;
    int           checksDone;

    odurc_update_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .frameValid(frameValid), .frameData(frameData),
        .load_strobe_n(load_strobe_n), .clear_n(clear_n), .clear_level_select(clear_level_select),
        .dacCode(dacCode), .pwrdnMode(pwrdnMode), .chanPulldown(chanPulldown), .chanTristate(chanTristate),
        .initDone(initDone));

    odurc_frame_master master_u (.clk(clk), .frameValid(frameValid), .frameData(frameData));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] chan(input int n);
        return dacCode[n*16 +: 16];
    endfunction : chan

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : cycles

    task automatic frame(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] data);
        master_u.send(cmd, addr, data);
    endtask : frame

    // Strobe pulses last well over the two-stage synchroniser, or the edge may be missed
    task automatic pulse();
        load_strobe_n = 1'b0;
        cycles(5);
        load_strobe_n = 1'b1;
        cycles(3);
    endtask : pulse

    // Bounded wait for initialisation to finish
    task automatic waitInit();
        int k;
        k = 0;
        while (initDone !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        check("initDone", initDone, 1'b1);
    endtask : waitInit

    task automatic summarize();
        $display("Checks %0d, errors %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_powerup();
        load_strobe_n = 1'b0;
        cycles(8);
        check("init held", initDone, 1'b0);
        load_strobe_n = 1'b1;
        clear_n = 1'b1;
        waitInit();
        check("powerup code", dacCode, 128'h0);
        frame(4'h9, 4'h0, 16'hFFFF);
        check("after bad cmd", dacCode, 128'h0);
    endtask : t_powerup

    task automatic t_commands();
        frame(4'h1, 4'h1, 16'h1111);
        check("ch1 deferred", chan(1), 16'h0000);
        frame(4'h2, 4'h1, 16'h0000);
        check("ch1 copy", chan(1), 16'h1111);
        frame(4'h3, 4'h2, 16'h2222);
        check("ch2 direct", chan(2), 16'h2222);
        frame(4'h1, 4'h0, 16'h0ABC);
        pulse();
        check("ch0 default mask", chan(0), 16'h0ABC);
    endtask : t_commands

    task automatic t_mask();
        frame(4'h1, 4'h3, 16'h3333);
        frame(4'h1, 4'h4, 16'h4444);
        frame(4'h5, 4'hF, 16'h0008);
        pulse();
        check("ch4 strobe", chan(4), 16'h4444);
        check("ch3 masked", chan(3), 16'h0000);
        frame(4'h5, 4'h0, 16'h0000);
        pulse();
        check("ch3 unmasked", chan(3), 16'h3333);
    endtask : t_mask

    task automatic t_level();
        frame(4'h5, 4'h0, 16'h00FF);
        load_strobe_n = 1'b0;
        cycles(3);
        frame(4'h1, 4'h5, 16'h5555);
        check("ch5 level", chan(5), 16'h5555);
        frame(4'h1, 4'h0, 16'h0555);
        check("ch0 level", chan(0), 16'h0555);
        load_strobe_n = 1'b1;
        cycles(3);
        frame(4'h5, 4'h0, 16'h0000);
    endtask : t_level

    task automatic t_pwrdn();
        frame(4'h4, 4'h0, 16'hC001);
        check("pd modes", pwrdnMode, 16'hC001);
        check("pulldown", chanPulldown, 8'h01);
        check("tristate", chanTristate, 8'h80);
        frame(4'h4, 4'h8, 16'h0000);
        check("pd bit19 set", pwrdnMode, 16'hC001);
        frame(4'h3, 4'h0, 16'h7777);
        check("write in pd", chan(0), 16'h7777);
        frame(4'h4, 4'h0, 16'h0000);
    endtask : t_pwrdn

    task automatic t_clear();
        clear_level_select = 1'b1;
        cycles(3);
        clear_n = 1'b0;
        cycles(4);
        check("clear mid", dacCode, {8{16'h8000}});
        frame(4'h3, 4'h1, 16'h9999);
        check("write blocked", chan(1), 16'h8000);
        clear_n = 1'b1;
        cycles(4);
        check("clear held", dacCode, {8{16'h8000}});
        pulse();
        check("strobe after clear", dacCode, {8{16'h8000}});
    endtask : t_clear

    task automatic t_soft();
        frame(4'h5, 4'h0, 16'h0004);
        frame(4'h3, 4'h2, 16'h2222);
        frame(4'h6, 4'h1, 16'h1234);
        frame(4'h6, 4'h0, 16'h1235);
        check("no soft reset", chan(2), 16'h2222);
        frame(4'h6, 4'h0, 16'h1234);
        check("soft reset init", initDone, 1'b0);
        waitInit();
        check("soft reset code", dacCode, {8{16'h8000}});
        frame(4'h1, 4'h2, 16'hABCD);
        pulse();
        check("mask after soft reset", chan(2), 16'hABCD);
    endtask : t_soft

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: inputs change on the falling edge only
    initial begin
        errTotal = 0;
        checksDone = 0;
        sys_rst = 1'b1;
        load_strobe_n = 1'b1;
        clear_n = 1'b0;
        clear_level_select = 1'b0;
        cycles(2);
        sys_rst = 1'b0;
        t_powerup();
        t_commands();
        t_mask();
        t_level();
        t_pwrdn();
        t_clear();
        t_soft();
        summarize();
    end

    // Watchdog: the sequence needs well under the 10000 cycles allowed here
    initial begin
        #40000;
        errTotal++;
        summarize();
    end

endmodule : tb_odurc_update_ctrl
